// File: common/estc_params.svh
`ifndef ESTC_PARAMS_SVH
`define ESTC_PARAMS_SVH

// register byte offsets on the apb bus
`define ESTC_CTRL_OFS 8'h00
`define ESTC_EXPO_OFS 8'h04
`define ESTC_PERIOD_OFS 8'h08
`define ESTC_TDUR_OFS 8'h0C
`define ESTC_CMD_OFS 8'h10
`define ESTC_STATUS_OFS 8'h14

// control register field positions
`define ESTC_CTRL_TRIG_EN 0
`define ESTC_CTRL_SRC_LSB 1
`define ESTC_CTRL_SRC_MSB 3
`define ESTC_CTRL_RISING 4
`define ESTC_CTRL_WIDTH 5
`define ESTC_CTRL_TMR_LEVEL 6
`define ESTC_CTRL_USER_BIT 7

// command register bits, write one to fire
`define ESTC_CMD_SW_TRIG 0
`define ESTC_CMD_ACQ_START 1
`define ESTC_CMD_ACQ_STOP 2

// status register field positions
`define ESTC_STAT_WAITING 0
`define ESTC_STAT_EXPOSING 1
`define ESTC_STAT_ACQ 2
`define ESTC_STAT_FRAMES_LSB 16

// timing: clock period and reset values of the time registers
`define ESTC_CLK_PERIOD_PS 5000
`define ESTC_EXPO_RST_NS 10000
`define ESTC_EXPO_RST_CYC ((`ESTC_EXPO_RST_NS * 1000 + `ESTC_CLK_PERIOD_PS - 1) / `ESTC_CLK_PERIOD_PS)
`define ESTC_PERIOD_RST_NS 100000
`define ESTC_PERIOD_RST_CYC ((`ESTC_PERIOD_RST_NS * 1000) / `ESTC_CLK_PERIOD_PS)
`define ESTC_TDUR_RST_NS 10000
`define ESTC_TDUR_RST_CYC ((`ESTC_TDUR_RST_NS * 1000 + `ESTC_CLK_PERIOD_PS - 1) / `ESTC_CLK_PERIOD_PS)

`endif

// File: common/estc_pkg.sv
`default_nettype none

package estc_pkg;

  // trigger source selection
  typedef enum logic [2:0] {
    src_software,
    user_output_bit_source,
    grabber_link_trigger_source,
    timer_active_output_source,
    external_input_pin_source
  } estc_src_type;

  // exposure sequencer states
  typedef enum logic [1:0] {
    st_wait,
    st_timed,
    st_width
  } estc_state_type;

  // pin synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } estc_sync_type;

  // whole state of the trigger controller
  typedef struct packed {
    estc_state_type st;
    logic acq;
    logic trig_en;
    estc_src_type src;
    logic rising;
    logic pulse_width_shutter;
    logic tmr_level;
    logic user_bit;
    logic [31:0] expo;
    logic [31:0] period;
    logic [31:0] tdur;
    logic [31:0] cnt;
    logic [31:0] fr_cnt;
    logic [15:0] frames;
    logic act_prev;
    logic sw_pend;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic expo_out;
    logic start_pulse;
    logic waiting;
  } estc_regs_type;

endpackage : estc_pkg

`default_nettype wire

// File: logic/estc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// three-stage synchroniser; a new level is accepted only when stages two and three agree
module estc_pin_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous pin
  input wire logic pin_in,
  // filtered level in the pclk domain
  output logic level
);
  import estc_pkg::*;

  estc_sync_type r_q; // registered state
  estc_sync_type r_d; // next state

  ////////////////////////////////////////////////////////////////////////////////
  // next state: stage one feeds only stage two, never the filter
  always_comb begin
    r_d = r_q;
    r_d.s1 = pin_in;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    // a change counts once the last two stages agree, which masks one-cycle glitches
    if (r_q.s2 == r_q.s3) begin
      r_d.level = r_q.s3;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign level = r_q.level;

endmodule : estc_pin_sync

`default_nettype wire

// File: logic/estc_trigger_ctrl.sv
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "estc_params.svh"

// Overview of operation
// - trigger off: exposure uses programmed duration
// - trigger on: only selected source starts frames
// - polarity setting picks rising or falling edge
// - software source always uses programmed duration
// - link or line: timed, or signal bounds width
// - timer edge activation: timed, or timer duration in width mode
// - timer level activation: timed, or external line bounds width
// - user bit: timed, or set-to-clear span
// - waiting state: software command starts exposure
// - exposure start leaves waiting, ignores further events
// - re-enter waiting automatically when able again
// - software trigger outside waiting is dropped
// - link edge per polarity starts only when waiting
// - one frame per link trigger period
// - each software command while waiting yields one start event
// - trigger off: free-run from start to stop
module estc_trigger_ctrl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger inputs
  input wire logic link_trigger_in,
  input wire logic external_input_pin_in,
  input wire logic timer_active_in,
  // exposure control outputs
  output logic exposure_active,
  output logic exposure_start,
  output logic waiting_for_trigger,
  output logic user_output_bit
);
  import estc_pkg::*;

  estc_regs_type r_q; // registered state
  estc_regs_type r_d; // next state
  logic link_lvl; // synchronised link trigger
  logic line_lvl; // synchronised external pin
  logic sel_lvl; // level of the selected source
  logic act_lvl; // selected level after polarity
  logic line_act; // external pin after polarity
  logic wr_fire; // write completes this edge
  logic start_ev; // raw start event
  logic start_ok; // start event accepted
  logic width_ctl; // exposure bounded by a signal
  logic tmr_edge_mode; // timer source with edge activation
  logic width_act; // level that holds a width exposure open
  logic [31:0] load_val; // duration for a timed exposure

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // polarity applied to a level: active high when rising edges are chosen
  function automatic logic apply_pol(input logic lvl, input logic rising);
    apply_pol = rising ? lvl : !lvl;
  endfunction : apply_pol

  // duration never below one cycle, so a zero setting cannot hang the counter
  function automatic logic [31:0] at_least_one(input logic [31:0] v);
    at_least_one = (v == 32'h0) ? 32'h1 : v;
  endfunction : at_least_one

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the timer output is on pclk and needs none
  estc_pin_sync u_link_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(link_trigger_in),
    .level(link_lvl)
  );

  estc_pin_sync u_line_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(external_input_pin_in),
    .level(line_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // source select and start qualification
  always_comb begin
    // pick the one selected source, others have no effect
    unique case (r_q.src)
      src_software: sel_lvl = 1'b0;
      user_output_bit_source: sel_lvl = r_q.user_bit;
      grabber_link_trigger_source: sel_lvl = link_lvl;
      timer_active_output_source: sel_lvl = timer_active_in;
      external_input_pin_source: sel_lvl = line_lvl;
      default: sel_lvl = 1'b0; // illegal codes select a low level, which reads active under falling polarity
    endcase
    act_lvl = apply_pol(sel_lvl, r_q.rising);
    line_act = apply_pol(line_lvl, r_q.rising);
    wr_fire = psel && penable && pwrite && r_q.pready;
    // raw event from free-run counter, software command or active edge
    if (!r_q.trig_en) begin
      start_ev = r_q.acq && (r_q.fr_cnt <= 32'h1);
    end else if (r_q.src == src_software) begin
      start_ev = r_q.acq && r_q.sw_pend;
    end else begin
      start_ev = r_q.acq && act_lvl && !r_q.act_prev;
    end
    // events outside the waiting state are dropped, not queued
    start_ok = start_ev && (r_q.st == st_wait);
    tmr_edge_mode = (r_q.src == timer_active_output_source) && !r_q.tmr_level;
    // software always timed; timer edge mode is timed, by the timer duration in width mode
    width_ctl = r_q.trig_en && r_q.pulse_width_shutter && (r_q.src != src_software)
                && !tmr_edge_mode;
    // timer level mode follows the external pin, all others their own source
    width_act = (r_q.src == timer_active_output_source) ? line_act : act_lvl;
    if (r_q.trig_en && r_q.pulse_width_shutter && tmr_edge_mode) begin
      load_val = at_least_one(r_q.tdur);
    end else begin
      load_val = at_least_one(r_q.expo);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state: bus, free-run counter and exposure sequencer
  always_comb begin
    r_d = r_q;
    r_d.start_pulse = 1'b0;
    r_d.sw_pend = 1'b0;
    r_d.pready = 1'b0;
    r_d.pslverr = 1'b0;
    // access phase: answer one cycle after it begins, data latched with pready
    if (psel && penable && !r_q.pready) begin
      r_d.pready = 1'b1;
      r_d.prdata = 32'h0;
      unique case (paddr)
        `ESTC_CTRL_OFS: begin
          r_d.prdata[`ESTC_CTRL_TRIG_EN] = r_q.trig_en;
          r_d.prdata[`ESTC_CTRL_SRC_MSB:`ESTC_CTRL_SRC_LSB] = r_q.src;
          r_d.prdata[`ESTC_CTRL_RISING] = r_q.rising;
          r_d.prdata[`ESTC_CTRL_WIDTH] = r_q.pulse_width_shutter;
          r_d.prdata[`ESTC_CTRL_TMR_LEVEL] = r_q.tmr_level;
          r_d.prdata[`ESTC_CTRL_USER_BIT] = r_q.user_bit;
        end
        `ESTC_EXPO_OFS: r_d.prdata = r_q.expo;
        `ESTC_PERIOD_OFS: r_d.prdata = r_q.period;
        `ESTC_TDUR_OFS: r_d.prdata = r_q.tdur;
        `ESTC_CMD_OFS: r_d.prdata = 32'h0; // commands read as zero
        `ESTC_STATUS_OFS: begin
          r_d.prdata[`ESTC_STAT_WAITING] = r_q.waiting;
          r_d.prdata[`ESTC_STAT_EXPOSING] = r_q.expo_out;
          r_d.prdata[`ESTC_STAT_ACQ] = r_q.acq;
          r_d.prdata[`ESTC_STAT_FRAMES_LSB +: 16] = r_q.frames;
        end
        default: r_d.pslverr = 1'b1; // unmapped address
      endcase
    end
    // writes take effect on the edge that completes the transfer
    if (wr_fire) begin
      unique case (paddr)
        `ESTC_CTRL_OFS: begin
          // source and polarity land together; ordering is the caller's concern
          r_d.trig_en = pwdata[`ESTC_CTRL_TRIG_EN];
          r_d.src = estc_src_type'(pwdata[`ESTC_CTRL_SRC_MSB:`ESTC_CTRL_SRC_LSB]);
          r_d.rising = pwdata[`ESTC_CTRL_RISING];
          r_d.pulse_width_shutter = pwdata[`ESTC_CTRL_WIDTH];
          r_d.tmr_level = pwdata[`ESTC_CTRL_TMR_LEVEL];
          r_d.user_bit = pwdata[`ESTC_CTRL_USER_BIT];
        end
        `ESTC_EXPO_OFS: r_d.expo = pwdata;
        `ESTC_PERIOD_OFS: r_d.period = pwdata;
        `ESTC_TDUR_OFS: r_d.tdur = pwdata;
        `ESTC_CMD_OFS: begin
          r_d.sw_pend = pwdata[`ESTC_CMD_SW_TRIG];
          // stop wins over start; a running exposure still completes
          if (pwdata[`ESTC_CMD_ACQ_START]) begin
            r_d.acq = 1'b1;
          end
          if (pwdata[`ESTC_CMD_ACQ_STOP]) begin
            r_d.acq = 1'b0;
          end
        end
        default: ; // status is read only, unmapped writes dropped
      endcase
    end
    // edge history always follows, so edges seen while busy are lost
    r_d.act_prev = act_lvl;
    // free-run frame period counter, first frame right after start
    if (r_q.acq && !r_q.trig_en) begin
      r_d.fr_cnt = (r_q.fr_cnt <= 32'h1) ? at_least_one(r_q.period) : r_q.fr_cnt - 32'h1;
    end else begin
      r_d.fr_cnt = 32'h1;
    end
    // exposure sequencer
    unique case (r_q.st)
      st_wait: begin
        if (start_ok) begin
          r_d.start_pulse = 1'b1;
          r_d.frames = r_q.frames + 16'h1;
          if (width_ctl) begin
            r_d.st = st_width;
          end else begin
            r_d.st = st_timed;
            r_d.cnt = load_val;
          end
        end
      end
      st_timed: begin
        // rearm with no command once the programmed length has run
        if (r_q.cnt <= 32'h1) begin
          r_d.st = st_wait;
        end else begin
          r_d.cnt = r_q.cnt - 32'h1;
        end
      end
      st_width: begin
        // trailing edge of the controlling signal ends the exposure
        if (!width_act) begin
          r_d.st = st_wait;
        end
      end
    endcase
    r_d.expo_out = (r_d.st != st_wait);
    r_d.waiting = (r_d.st == st_wait) && r_d.acq;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
      r_q.st <= st_wait;
      r_q.src <= src_software;
      r_q.rising <= 1'b1;
      r_q.expo <= 32'(`ESTC_EXPO_RST_CYC);
      r_q.period <= 32'(`ESTC_PERIOD_RST_CYC);
      r_q.tdur <= 32'(`ESTC_TDUR_RST_CYC);
      r_q.fr_cnt <= 32'h1;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from the state register
  assign prdata = r_q.prdata;
  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;
  assign exposure_active = r_q.expo_out;
  assign exposure_start = r_q.start_pulse;
  assign waiting_for_trigger = r_q.waiting;
  assign user_output_bit = r_q.user_bit;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a timed exposure counts down one per cycle to the end
  sequence s_timed_step;
    (r_q.st == st_timed) && (r_q.cnt > 32'h1);
  endsequence
  sequence s_timed_next;
    (r_q.st == st_timed) && (r_q.cnt == $past(r_q.cnt) - 32'h1);
  endsequence

  a_timed_countdown: assert property (s_timed_step |=> s_timed_next)
    else $error("timed exposure did not count down by one");
  a_timed_rearm: assert property ((r_q.st == st_timed) && (r_q.cnt == 32'h1) |=> r_q.st == st_wait)
    else $error("no rearm at end of timed exposure");
  a_width_end: assert property ((r_q.st == st_width) && !width_act |=> !exposure_active)
    else $error("width exposure outlived its trigger level");
  a_start_leaves_wait: assert property (exposure_start |-> exposure_active && !waiting_for_trigger)
    else $error("start pulse while still waiting");
  a_sw_discard: assert property (r_q.sw_pend && (r_q.st != st_wait) |=> !exposure_start)
    else $error("software trigger honoured outside waiting state");
  a_sw_timed: assert property (exposure_start && r_q.trig_en && (r_q.src == src_software)
    |-> $past(r_q.sw_pend) && (r_q.st == st_timed))
    else $error("software start not timed or without command");
  a_edge_polarity: assert property (exposure_start && r_q.trig_en && (r_q.src != src_software)
    |-> $past(act_lvl) && !$past(r_q.act_prev))
    else $error("hardware start without active edge");
  a_timer_load: assert property (start_ok && r_q.trig_en && r_q.pulse_width_shutter && tmr_edge_mode
    |=> (r_q.st == st_timed) && (r_q.cnt == at_least_one($past(r_q.tdur))))
    else $error("timer edge mode not timed by timer duration");
  a_free_run: assert property (!r_q.trig_en && r_q.acq && (r_q.fr_cnt == 32'h1) && (r_q.st == st_wait)
    |=> exposure_start)
    else $error("free-run start missed");
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered in one cycle");

endmodule : estc_trigger_ctrl

`default_nettype wire

// File: bench/estc_trig_src.sv
`timescale 1ns/1ps
`default_nettype none

// far-side trigger driver: grabber link and external pin, both plain levels
module estc_trig_src (
  // clock
  input wire logic pclk,
  // trigger lines
  output logic link_trigger_in,
  output logic external_input_pin_in
);

  // both lines rest low until a polarity is chosen
  initial begin
    link_trigger_in = 1'b0;
    external_input_pin_in = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // park a line at its inactive level; do it while acquisition is stopped
  task idle(input logic on_link, input logic rising);
    @(posedge pclk);
    if (on_link) link_trigger_in <= ~rising;
    else external_input_pin_in <= ~rising;
  endtask : idle

  // one active pulse of w cycles, then a quiet gap
  task pulse(input logic on_link, input logic rising, input int w);
    @(posedge pclk);
    if (on_link) link_trigger_in <= rising;
    else external_input_pin_in <= rising;
    repeat (w) @(posedge pclk);
    if (on_link) link_trigger_in <= ~rising;
    else external_input_pin_in <= ~rising;
    // the gap keeps the trigger rate well under the frame limit
    repeat (40) @(posedge pclk);
  endtask : pulse

endmodule : estc_trig_src

`default_nettype wire

// File: bench/estc_trigger_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "estc_params.svh"

// self-checking bench for the exposure trigger controller
module estc_trigger_ctrl_test;
  import estc_pkg::*;

  // clock, reset and apb
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  // trigger lines and exposure outputs
  logic link_trigger_in, external_input_pin_in, timer_active_in;
  logic exposure_active, exposure_start, waiting_for_trigger, user_output_bit;
  // model: queues of allowed exposure lengths, free-run flag
  int lo_q[$], hi_q[$];
  int n_errors, n_tests, cur, cyc, expo, n_starts, w, lo, hi;
  logic free;

  estc_trigger_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_trigger_in(link_trigger_in),
    .external_input_pin_in(external_input_pin_in), .timer_active_in(timer_active_in),
    .exposure_active(exposure_active), .exposure_start(exposure_start),
    .waiting_for_trigger(waiting_for_trigger), .user_output_bit(user_output_bit));

  estc_trig_src src (.pclk(pclk), .link_trigger_in(link_trigger_in),
    .external_input_pin_in(external_input_pin_in));

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////
  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; holds everything until pready is seen
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // control word: enable set, user bit last
  function logic [31:0] cw(input logic [2:0] s, input logic r, wd, tl, ub);
    return {24'h0, ub, tl, wd, r, s, 1'b1};
  endfunction : cw

  // source first, polarity after, all while acquisition is stopped
  task cfg(input logic [2:0] s, input logic r, input logic wd, input logic tl);
    apb(1'b1, `ESTC_CMD_OFS, 32'h4);
    apb(1'b1, `ESTC_CTRL_OFS, cw(s, 1'b0, wd, tl, 1'b0));
    apb(1'b1, `ESTC_CTRL_OFS, cw(s, r, wd, tl, 1'b0));
    apb(1'b1, `ESTC_CMD_OFS, 32'h2);
  endtask : cfg

  // queue one allowed exposure length range
  task expect_len(input int l, input int h);
    lo_q.push_back(l);
    hi_q.push_back(h);
  endtask : expect_len

  // timer output pulse, same clock domain
  task tmr_pulse;
    @(posedge pclk);
    timer_active_in <= 1'b1;
    repeat (3) @(posedge pclk);
    timer_active_in <= 1'b0;
  endtask : tmr_pulse

  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////
  // exposure monitor: every finished exposure must match the model
  always @(posedge pclk) begin
    if (presetn === 1'b1) begin
      if (exposure_start === 1'b1) n_starts++;
      if (exposure_active === 1'b1) cur++;
      else if (cur != 0) begin
        if (lo_q.size() != 0) begin
          lo = lo_q.pop_front();
          hi = hi_q.pop_front();
          chk(cur >= lo && cur <= hi, 1);
        end else if (free) chk(cur, expo);
        else chk(cur, 0);
        cur = 0;
      end
    end
  end

  // hang guard, far above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'hE6DDF266));
    {presetn, psel, penable, pwrite, timer_active_in, free} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped address
    apb(1'b0, `ESTC_CTRL_OFS, 32'h0);
    chk(rdat, 32'h10);
    apb(1'b0, `ESTC_EXPO_OFS, 32'h0);
    chk(rdat, `ESTC_EXPO_RST_CYC);
    apb(1'b0, 8'h40, 32'h0);
    // error flag and data compared apart, a 33-bit pair would lose the flag
    chk(err_seen, 32'h1);
    chk(rdat, 32'h0);
    // free run: start to stop, programmed length
    expo = 4 + $urandom % 8;
    apb(1'b1, `ESTC_EXPO_OFS, expo);
    apb(1'b1, `ESTC_PERIOD_OFS, 32'h3C);
    free = 1'b1;
    apb(1'b1, `ESTC_CMD_OFS, 32'h2);
    repeat (300) @(posedge pclk);
    chk(n_starts >= 4, 1);
    apb(1'b1, `ESTC_CMD_OFS, 32'h4);
    repeat (30) @(posedge pclk);
    w = n_starts;
    repeat (200) @(posedge pclk);
    chk(n_starts, w);
    free = 1'b0;
    // software trigger; width mode must not matter, a repeat is dropped
    cfg(src_software, 1'b1, 1'b1, 1'b0);
    repeat (3) begin
      expect_len(expo, expo);
      apb(1'b1, `ESTC_CMD_OFS, 32'h1);
      apb(1'b1, `ESTC_CMD_OFS, 32'h1);
      repeat (30) @(posedge pclk);
      chk(waiting_for_trigger, 1'b1);
    end
    // link and pin, both polarities and modes; the other line is ignored
    for (int k = 0; k < 8; k++) begin
      // stop first, so moving a line to its new idle level cannot fire the old source
      apb(1'b1, `ESTC_CMD_OFS, 32'h4);
      src.idle(k[2], k[0]);
      src.idle(~k[2], k[0]);
      cfg(k[2] ? grabber_link_trigger_source : external_input_pin_source, k[0], k[1], 1'b0);
      src.pulse(~k[2], k[0], 8);
      repeat (2) begin
        w = 6 + $urandom % 10;
        if (k[1]) expect_len(w, w + 6);
        else expect_len(expo, expo);
        src.pulse(k[2], k[0], w);
      end
      chk(lo_q.size(), 0);
    end
    // user bit: timed, then set-to-clear span
    for (int k = 0; k < 2; k++) begin
      cfg(user_output_bit_source, 1'b1, k[0], 1'b0);
      if (k[0]) expect_len(10, 16);
      else expect_len(expo, expo);
      apb(1'b1, `ESTC_CTRL_OFS, cw(user_output_bit_source, 1'b1, k[0], 1'b0, 1'b1));
      repeat (10) @(posedge pclk);
      chk(user_output_bit, 1'b1);
      apb(1'b1, `ESTC_CTRL_OFS, cw(user_output_bit_source, 1'b1, k[0], 1'b0, 1'b0));
      repeat (40) @(posedge pclk);
    end
    // timer edge activation lasts the timer duration
    w = 5 + $urandom % 10;
    apb(1'b1, `ESTC_TDUR_OFS, w);
    cfg(timer_active_output_source, 1'b1, 1'b1, 1'b0);
    expect_len(w, w);
    tmr_pulse();
    repeat (40) @(posedge pclk);
    // timer level activation: the pin ends the exposure
    src.idle(1'b0, 1'b1);
    cfg(timer_active_output_source, 1'b1, 1'b1, 1'b1);
    expect_len(18, 28);
    fork
      src.pulse(1'b0, 1'b1, 30);
      begin
        repeat (10) @(posedge pclk);
        tmr_pulse();
      end
    join
    chk(lo_q.size(), 0);
    complete_run();
  end

endmodule : estc_trigger_ctrl_test

`default_nettype wire
